// [sse_map.svh]
`ifndef SSE_MAP_SVH
`define SSE_MAP_SVH

// AXI4-Lite register byte offsets
`define SSE_CTRL_OFS 8'h00
`define SSE_OPERAND_OFS 8'h04
`define SSE_SP_OFS 8'h08
`define SSE_STATUS_OFS 8'h0C
`define SSE_PC_OFS 8'h10
`define SSE_RESULT_OFS 8'h14
`define SSE_STATE_OFS 8'h18

// Control register fields
`define SSE_CTRL_GO_BIT 0
`define SSE_CTRL_BYTE_BIT 1
`define SSE_CTRL_OP_LSB 4

// Status register field positions
`define SSE_C_BIT 0
`define SSE_Z_BIT 1
`define SSE_N_BIT 2
`define SSE_IRQ_MASK_BIT 3
`define SSE_HALT_BIT 4
`define SSE_OSC_DIS_BIT 5
`define SSE_V_BIT 8
`define SSE_PCHI_LSB 12

// Stack pointer step and overflow windows
`define SSE_SP_STEP 20'h00002
`define SSE_OVW_LO 16'h4000
`define SSE_OVW_HI 16'hC000
`define SSE_OVB_LO 8'h40
`define SSE_OVB_HI 8'hC0

// Reset values
`define SSE_SP_RST 20'h00000
`define SSE_SR_RST 16'h0000
`define SSE_PC_RST 20'h00000

`endif

// [sse_pkg.sv]
`default_nettype none
package sse_pkg;
   typedef enum logic [2:0] {
      SSE_OP_PUSH,
      SSE_OP_POP,
      SSE_OP_SUBRET,
      SSE_OP_INTRET,
      SSE_OP_SHL,
      SSE_OP_ROTL,
      SSE_OP_SHR,
      SSE_OP_ROTR
   } sse_op_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [1:0] be;
   } sse_mem_req_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } sse_flags_t;
endpackage
`default_nettype wire

// [sse_stack_shift_exec.sv]
// How it works
// - pop reads stack word, bumps pointer, writes
// - push and pop always move pointer two
// - byte pop clears destination high byte
// - push decrements pointer, then writes word
// - byte push writes low byte only
// - push, pop, subroutine return keep arithmetic flags
// - these ops keep mode bits
// - subroutine return loads low counter, clears high
// - interrupt return pops status with counter high
// - second pop gives counter low bits
// - interrupt return restores flags and mode bits
// - shift left inserts zero, msb to carry
// - word left overflow window 4000h..BFFFh
// - byte left overflow window 40h..BFh
// - left ops set N, Z, carry from msb
// - rotate left puts carry into lsb
// - shift right keeps sign bit
// - rotate right puts carry into msb
// - right ops set N, Z, C, clear V
`timescale 1ns/1ps
`default_nettype none
`include "sse_map.svh"

module sse_stack_shift_exec (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output sse_pkg::sse_mem_req_t memReq,
   input wire logic memAck,
   input wire logic [15:0] memRdata
);

   typedef enum logic [2:0] {
      SSE_IDLE,
      SSE_MEM,
      SSE_SECOND,
      SSE_DONE
   } sse_state_t;

   // ==========================================================
   // Architectural state
   // ==========================================================
   logic [19:0] sp_reg;
   logic [15:0] sr_reg;
   logic [19:0] pc_reg;
   logic [15:0] operand_reg;
   logic [15:0] result_reg;
   logic [7:0] ctrl_reg;
   logic busy_reg;
   sse_state_t state_reg;
   sse_pkg::sse_mem_req_t memReq_reg;
   logic [15:0] temp_reg;

   sse_pkg::sse_op_t op;
   logic isByte;
   assign op = sse_pkg::sse_op_t'(ctrl_reg[`SSE_CTRL_OP_LSB +: 3]);
   assign isByte = ctrl_reg[`SSE_CTRL_BYTE_BIT];
   assign memReq = memReq_reg;

   // ==========================================================
   // AXI4-Lite slave
   // ==========================================================
   logic awHeld_reg;
   logic wHeld_reg;
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic doWrite;
   logic goPulse;

   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
   assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign goPulse = doWrite && awAddr_reg == `SSE_CTRL_OFS
      && wStrb_reg[0] && wData_reg[`SSE_CTRL_GO_BIT] && !busy_reg;
   assign s_axi_bresp = 2'h0;
   assign s_axi_rresp = 2'h0;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr[7:0])
               `SSE_CTRL_OFS: s_axi_rdata <= {24'h000000, ctrl_reg};
               `SSE_OPERAND_OFS: s_axi_rdata <= {16'h0000, operand_reg};
               `SSE_SP_OFS: s_axi_rdata <= {12'h000, sp_reg};
               `SSE_STATUS_OFS: s_axi_rdata <= {16'h0000, sr_reg};
               `SSE_PC_OFS: s_axi_rdata <= {12'h000, pc_reg};
               `SSE_RESULT_OFS: s_axi_rdata <= {16'h0000, result_reg};
               `SSE_STATE_OFS: s_axi_rdata <= {31'h0000_0000, busy_reg};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Shift and rotate datapath
   // ==========================================================
   logic [15:0] shRes;
   logic msbOld;
   logic lsbOld;
   logic cin;
   logic shV;
   logic resMsb;
   logic resZero;

   always_comb begin
      cin = sr_reg[`SSE_C_BIT];
      msbOld = isByte ? operand_reg[7] : operand_reg[15];
      lsbOld = operand_reg[0];
      shRes = 16'h0000;
      case (op)
         sse_pkg::SSE_OP_SHL: shRes = {operand_reg[14:0], 1'b0};
         sse_pkg::SSE_OP_ROTL: shRes = {operand_reg[14:0], cin};
         sse_pkg::SSE_OP_SHR: shRes = isByte
            ? {8'h00, operand_reg[7], operand_reg[7:1]}
            : {operand_reg[15], operand_reg[15:1]};
         // carry into msb on rotate right
         sse_pkg::SSE_OP_ROTR: shRes = isByte
            ? {8'h00, cin, operand_reg[7:1]}
            : {cin, operand_reg[15:1]};
         default: shRes = operand_reg;
      endcase
      if (isByte) shRes = {8'h00, shRes[7:0]};
      resMsb = isByte ? shRes[7] : shRes[15];
      resZero = isByte ? (shRes[7:0] == 8'h00) : (shRes == 16'h0000);
      shV = isByte
         ? (operand_reg[7:0] >= `SSE_OVB_LO && operand_reg[7:0] < `SSE_OVB_HI)
         : (operand_reg >= `SSE_OVW_LO && operand_reg < `SSE_OVW_HI);
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= SSE_IDLE;
         busy_reg <= 1'b0;
         memReq_reg <= '0;
         temp_reg <= 16'h0000;
         result_reg <= 16'h0000;
         sp_reg <= `SSE_SP_RST;
         sr_reg <= `SSE_SR_RST;
         pc_reg <= `SSE_PC_RST;
         ctrl_reg <= 8'h00;
         operand_reg <= 16'h0000;
      end else if (ce) begin
         if (doWrite && !busy_reg) begin
            if (awAddr_reg == `SSE_CTRL_OFS && wStrb_reg[0]) ctrl_reg <= {wData_reg[7:1], 1'b0};
            if (awAddr_reg == `SSE_OPERAND_OFS) begin
               if (wStrb_reg[0]) operand_reg[7:0] <= wData_reg[7:0];
               if (wStrb_reg[1]) operand_reg[15:8] <= wData_reg[15:8];
            end
            if (awAddr_reg == `SSE_SP_OFS) sp_reg <= wData_reg[19:0];
            if (awAddr_reg == `SSE_STATUS_OFS) sr_reg <= wData_reg[15:0];
            if (awAddr_reg == `SSE_PC_OFS) pc_reg <= wData_reg[19:0];
         end
         case (state_reg)
            SSE_IDLE: begin
               if (goPulse) begin
                  busy_reg <= 1'b1;
                  case (sse_pkg::sse_op_t'(wData_reg[`SSE_CTRL_OP_LSB +: 3]))
                     sse_pkg::SSE_OP_PUSH: begin
                        sp_reg <= sp_reg - `SSE_SP_STEP;
                        memReq_reg.req <= 1'b1;
                        memReq_reg.we <= 1'b1;
                        memReq_reg.addr <= sp_reg - `SSE_SP_STEP;
                        memReq_reg.wdata <= operand_reg;
                        memReq_reg.be <= wData_reg[`SSE_CTRL_BYTE_BIT] ? 2'h1 : 2'h3;
                        state_reg <= SSE_MEM;
                     end
                     sse_pkg::SSE_OP_POP, sse_pkg::SSE_OP_SUBRET,
                     sse_pkg::SSE_OP_INTRET: begin
                        memReq_reg.req <= 1'b1;
                        memReq_reg.we <= 1'b0;
                        memReq_reg.addr <= sp_reg;
                        memReq_reg.be <= 2'h3;
                        state_reg <= SSE_MEM;
                     end
                     default: state_reg <= SSE_DONE;
                  endcase
               end
            end
            SSE_MEM: begin
               if (memAck) begin
                  memReq_reg.req <= 1'b0;
                  state_reg <= SSE_DONE;
                  case (op)
                     sse_pkg::SSE_OP_POP: begin
                        temp_reg <= memRdata;
                        sp_reg <= sp_reg + `SSE_SP_STEP;
                     end
                     sse_pkg::SSE_OP_SUBRET: begin
                        // low counter bits loaded, high cleared
                        pc_reg <= {4'h0, memRdata};
                        sp_reg <= sp_reg + `SSE_SP_STEP;
                     end
                     sse_pkg::SSE_OP_INTRET: begin
                        // status word carries counter high bits
                        sr_reg <= memRdata;
                        pc_reg[19:16] <= memRdata[`SSE_PCHI_LSB +: 4];
                        sp_reg <= sp_reg + `SSE_SP_STEP;
                        memReq_reg.req <= 1'b1;
                        memReq_reg.addr <= sp_reg + `SSE_SP_STEP;
                        state_reg <= SSE_SECOND;
                     end
                     default: ;
                  endcase
               end
            end
            SSE_SECOND: begin
               if (memAck) begin
                  // second pop gives low counter bits
                  memReq_reg.req <= 1'b0;
                  pc_reg[15:0] <= memRdata;
                  sp_reg <= sp_reg + `SSE_SP_STEP;
                  state_reg <= SSE_DONE;
               end
            end
            SSE_DONE: begin
               case (op)
                  sse_pkg::SSE_OP_POP: result_reg <= isByte ? {8'h00, temp_reg[7:0]} : temp_reg;
                  sse_pkg::SSE_OP_SHL, sse_pkg::SSE_OP_ROTL,
                  sse_pkg::SSE_OP_SHR, sse_pkg::SSE_OP_ROTR: begin
                     result_reg <= shRes;
                     sr_reg[`SSE_N_BIT] <= resMsb;
                     sr_reg[`SSE_Z_BIT] <= resZero;
                     // left ops carry from old msb
                     // right ops carry from lsb, V cleared
                     if (op == sse_pkg::SSE_OP_SHL || op == sse_pkg::SSE_OP_ROTL) begin
                        sr_reg[`SSE_C_BIT] <= msbOld;
                        sr_reg[`SSE_V_BIT] <= shV;
                     end else begin
                        sr_reg[`SSE_C_BIT] <= lsbOld;
                        sr_reg[`SSE_V_BIT] <= 1'b0;
                     end
                  end
                  default: ;
               endcase
               busy_reg <= 1'b0;
               state_reg <= SSE_IDLE;
            end
            default: state_reg <= SSE_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cbCore @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_push_sp;
         (ce && goPulse && wData_reg[6:4] == 3'h0) |=> sp_reg == $past(sp_reg) - 20'h00002;
   endproperty
   a_push_sp: assert property (p_push_sp) else $error("push pointer step wrong");
   property p_pop_sp;
         (ce && state_reg == SSE_MEM && memAck && op == sse_pkg::SSE_OP_POP)
         |=> sp_reg == $past(sp_reg) + 20'h00002;
   endproperty
   a_pop_sp: assert property (p_pop_sp) else $error("pop pointer step wrong");
   property p_byte_pop;
         (ce && state_reg == SSE_DONE && op == sse_pkg::SSE_OP_POP && isByte)
         |=> result_reg == {8'h00, $past(temp_reg[7:0])};
   endproperty
   a_byte_pop: assert property (p_byte_pop) else $error("byte pop result wrong");
   property p_byte_push;
         (memReq_reg.req && memReq_reg.we && isByte) |-> memReq_reg.be == 2'h1;
   endproperty
   a_byte_push: assert property (p_byte_push) else $error("byte push enables wrong");
   property p_ret_pc;
         (ce && state_reg == SSE_MEM && memAck && op == sse_pkg::SSE_OP_SUBRET)
         |=> pc_reg == {4'h0, $past(memRdata)};
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("return counter wrong");
   property p_interrupt_exit_op_sr;
         (ce && state_reg == SSE_MEM && memAck && op == sse_pkg::SSE_OP_INTRET)
         |=> sr_reg == $past(memRdata) && state_reg == SSE_SECOND;
   endproperty
   a_interrupt_exit_op_sr: assert property (p_interrupt_exit_op_sr) else $error("status not restored");
   property p_stack_flags;
         (state_reg == SSE_DONE && (op == sse_pkg::SSE_OP_PUSH || op == sse_pkg::SSE_OP_POP))
         |=> sr_reg == $past(sr_reg);
   endproperty
   a_stack_flags: assert property (p_stack_flags) else $error("stack op changed flags");
   property p_right_v;
         (ce && state_reg == SSE_DONE && (op == sse_pkg::SSE_OP_SHR || op == sse_pkg::SSE_OP_ROTR))
         |=> !sr_reg[`SSE_V_BIT] && sr_reg[`SSE_C_BIT] == $past(operand_reg[0]);
   endproperty
   a_right_v: assert property (p_right_v) else $error("right shift flags wrong");
   property p_mode_keep;
         (ce && state_reg == SSE_DONE && op != sse_pkg::SSE_OP_INTRET)
         |=> sr_reg[5:3] == $past(sr_reg[5:3]);
   endproperty
   a_mode_keep: assert property (p_mode_keep) else $error("mode bits changed");

endmodule
`default_nettype wire

// [sse_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Stack memory on the far side of the core
// ==========================================
module sse_mem_model (
   input wire logic clk,
   input wire logic slow,
   input wire sse_pkg::sse_mem_req_t memReq,
   output logic memAck,
   output logic [15:0] memRdata
);
   logic [15:0] mem [0:4095];
   logic [1:0] waitCnt;

   initial begin
      memAck = 1'b0;
      memRdata = 16'h0000;
      waitCnt = 2'h0;
   end

   // Slow mode stalls each access three extra cycles; idle read data keeps toggling
   always @(posedge clk) begin
      if (memReq.req && !memAck && (!slow || waitCnt == 2'h3)) begin
         memAck <= 1'b1;
         waitCnt <= 2'h0;
         if (memReq.we) begin
            if (memReq.be[0]) mem[memReq.addr[12:1]][7:0] <= memReq.wdata[7:0];
            if (memReq.be[1]) mem[memReq.addr[12:1]][15:8] <= memReq.wdata[15:8];
            memRdata <= ~memRdata;
         end else begin
            memRdata <= mem[memReq.addr[12:1]];
         end
      end else begin
         memAck <= 1'b0;
         memRdata <= ~memRdata;
         if (memReq.req && !memAck) waitCnt <= waitCnt + 2'h1;
      end
   end
endmodule

`default_nettype wire

// [sse_stack_shift_exec_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sse_map.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module sse_stack_shift_exec_tb;
   typedef struct {logic [2:0] op; logic byt; logic [15:0] opnd, srIn, res, srOut;} sse_row_t;
   logic clk, rst, ce, slowMem;
   logic [31:0] awAddr, wData, arAddr, rData;
   logic [3:0] wStrb;
   logic awValid, wValid, bReady, arValid, rReady;
   logic awReady, wReady, bValid, arReady, rValid, memAck;
   logic [1:0] bResp, rResp;
   logic [15:0] memRdata;
   sse_pkg::sse_mem_req_t memReq;
   int miscompares, checked;
   sse_row_t rows [14] = '{
      '{3'h4, 1'b0, 16'h4000, 16'h0038, 16'h8000, 16'h013C},
      '{3'h4, 1'b0, 16'hC000, 16'h0000, 16'h8000, 16'h0005},
      '{3'h4, 1'b0, 16'h3FFF, 16'h0001, 16'h7FFE, 16'h0000},
      '{3'h4, 1'b0, 16'h8000, 16'h0000, 16'h0000, 16'h0103},
      '{3'h5, 1'b0, 16'hBFFF, 16'h0039, 16'h7FFF, 16'h0139},
      '{3'h4, 1'b1, 16'h0040, 16'h0000, 16'h0080, 16'h0104},
      '{3'h5, 1'b1, 16'h00C0, 16'h0001, 16'h0081, 16'h0005},
      '{3'h4, 1'b1, 16'hFF3F, 16'h0000, 16'h007E, 16'h0000},
      '{3'h6, 1'b0, 16'h8001, 16'h0100, 16'hC000, 16'h0005},
      '{3'h6, 1'b0, 16'h0001, 16'h0000, 16'h0000, 16'h0003},
      '{3'h7, 1'b0, 16'h0002, 16'h0001, 16'h8001, 16'h0004},
      '{3'h7, 1'b1, 16'h0001, 16'h0038, 16'h0000, 16'h003B},
      '{3'h6, 1'b1, 16'h0080, 16'h0000, 16'h00C0, 16'h0004},
      '{3'h7, 1'b1, 16'h5501, 16'h0001, 16'h0080, 16'h0005}};

   sse_stack_shift_exec u_sse_stack_shift_exec (.clk(clk), .rst(rst), .ce(ce),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .memReq(memReq), .memAck(memAck), .memRdata(memRdata));

   sse_mem_model u_sse_mem_model (.clk(clk), .slow(slowMem), .memReq(memReq),
      .memAck(memAck), .memRdata(memRdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // Bus tasks
   // ==========================================
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic awT, wT, bT;
      bit fin;
      int n;
      @(posedge clk);
      fin = 1'b0;
      n = 0;
      awAddr <= {24'h000000, a};
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      while (!fin && n < 100) begin
         @(negedge clk);
         awT = awValid && awReady;
         wT = wValid && wReady;
         bT = bValid;
         if (bT) `CHK(bResp, 2'h0)
         @(posedge clk);
         if (awT) awValid <= 1'b0;
         if (wT) wValid <= 1'b0;
         if (bT) bReady <= 1'b0;
         fin = bT;
         n++;
      end
      if (!fin) miscompares++;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic arT, rT;
      bit fin;
      int n;
      @(posedge clk);
      fin = 1'b0;
      n = 0;
      d = 32'hFFFFFFFF;
      arAddr <= {24'h000000, a};
      arValid <= 1'b1;
      rReady <= 1'b1;
      while (!fin && n < 100) begin
         @(negedge clk);
         arT = arValid && arReady;
         rT = rValid;
         if (rT) d = rData;
         if (rT) `CHK(rResp, 2'h0)
         @(posedge clk);
         if (arT) arValid <= 1'b0;
         if (rT) rReady <= 1'b0;
         fin = rT;
         n++;
      end
      if (!fin) miscompares++;
   endtask

   task automatic look(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      `CHK(v, e)
   endtask

   task automatic run(input logic [2:0] op, input logic byt);
      logic [31:0] v;
      int n;
      n = 0;
      wr(`SSE_CTRL_OFS, {25'h0000000, op, 2'b00, byt, 1'b1});
      v = 32'h00000001;
      while (v[0] !== 1'b0 && n < 40) begin
         rd(`SSE_STATE_OFS, v);
         n++;
      end
      if (v[0] !== 1'b0) miscompares++;
   endtask

   task automatic complete_run();
      if (miscompares == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      slowMem = 1'b0;
      {awAddr, wData, arAddr, awValid, wValid, bReady, arValid, rReady} = '0;
      wStrb = 4'hF;
      miscompares = 0;
      checked = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Reset values, then the unmapped word at 1Ch
      for (int a = 8; a <= 28; a += 4) look(a[7:0], 32'h00000000);
      foreach (rows[i]) begin
         wr(`SSE_OPERAND_OFS, {16'h0000, rows[i].opnd});
         wr(`SSE_STATUS_OFS, {16'h0000, rows[i].srIn});
         run(rows[i].op, rows[i].byt);
         look(`SSE_RESULT_OFS, {16'h0000, rows[i].res});
         look(`SSE_STATUS_OFS, {16'h0000, rows[i].srOut});
      end
      u_sse_mem_model.mem[12'hFFE] = 16'h7700;
      wr(`SSE_SP_OFS, 32'h00010000);
      wr(`SSE_STATUS_OFS, 32'h0000013F);
      wr(`SSE_OPERAND_OFS, 32'h0000A55A);
      run(sse_pkg::SSE_OP_PUSH, 1'b0);
      look(`SSE_SP_OFS, 32'h0000FFFE);
      `CHK(u_sse_mem_model.mem[12'hFFF], 16'hA55A)
      slowMem <= 1'b1;
      wr(`SSE_OPERAND_OFS, 32'h000012CD);
      run(sse_pkg::SSE_OP_PUSH, 1'b1);
      look(`SSE_SP_OFS, 32'h0000FFFC);
      `CHK(u_sse_mem_model.mem[12'hFFE], 16'h77CD)
      look(`SSE_STATUS_OFS, 32'h0000013F);
      run(sse_pkg::SSE_OP_POP, 1'b1);
      look(`SSE_RESULT_OFS, 32'h000000CD);
      look(`SSE_SP_OFS, 32'h0000FFFE);
      run(sse_pkg::SSE_OP_POP, 1'b0);
      look(`SSE_RESULT_OFS, 32'h0000A55A);
      look(`SSE_SP_OFS, 32'h00010000);
      look(`SSE_STATUS_OFS, 32'h0000013F);
      u_sse_mem_model.mem[12'h000] = 16'h1234;
      wr(`SSE_PC_OFS, 32'h000F0000);
      run(sse_pkg::SSE_OP_SUBRET, 1'b0);
      look(`SSE_PC_OFS, 32'h00001234);
      look(`SSE_SP_OFS, 32'h00010002);
      look(`SSE_STATUS_OFS, 32'h0000013F);
      u_sse_mem_model.mem[12'h001] = 16'hA10A;
      u_sse_mem_model.mem[12'h002] = 16'h5678;
      run(sse_pkg::SSE_OP_INTRET, 1'b0);
      look(`SSE_STATUS_OFS, 32'h0000A10A);
      look(`SSE_PC_OFS, 32'h000A5678);
      look(`SSE_SP_OFS, 32'h00010006);
      complete_run();
   end

   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
endmodule

`default_nettype wire
